/* File: include/iscd_pkg.sv */
// Purpose: Constants for the subset-configuration decode block.
// Assumes: 32-bit instruction words, major opcode in bits 31..26.
// Notes: Releases are encoded as small integers.
package iscd_pkg;
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_COP0 = 6'h10;
  localparam logic [5:0] OP_COP1 = 6'h11;
  localparam logic [5:0] OP_COPROC2_OPCODE = 6'h12;
  localparam logic [5:0] OP_COPROC3_OPCODE = 6'h13;
  localparam logic [5:0] OP_VENDOR = 6'h1c;
  localparam logic [5:0] OP_MODE_JUMP = 6'h1d;
  localparam logic [5:0] OP_LWC1 = 6'h31;
  localparam logic [5:0] OP_LWC2 = 6'h32;
  localparam logic [5:0] OP_LDC1 = 6'h35;
  localparam logic [5:0] OP_LDC2 = 6'h36;
  localparam logic [5:0] OP_SWC1 = 6'h39;
  localparam logic [5:0] OP_SWC2 = 6'h3a;
  localparam logic [5:0] OP_SDC1 = 6'h3d;
  localparam logic [5:0] OP_SDC2 = 6'h3e;
  localparam logic [5:0] FN_MOVCI = 6'h01;
  localparam logic [5:0] FN_DEBUG_BREAK = 6'h0e;
  localparam logic [5:0] FN_DEBUG_RETURN = 6'h1f;
  localparam logic [2:0] REL_FIVE = 3'h5;
  localparam logic [2:0] REL_SIX = 3'h6;
  localparam logic [2:0] REL_TWO = 3'h2;
  localparam logic [1:0] AW_32 = 2'h0;
  localparam logic [1:0] AW_64 = 2'h2;
  localparam logic [2:0] LINE_NONE = 3'h0;
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_RESERVED = 2'h1;
  localparam logic [1:0] EXC_COP_UNUSABLE = 2'h2;
  typedef enum logic [1:0] {
    ISCD_BOOT = 2'b00,
    ISCD_CHECK = 2'b01,
    ISCD_RUN = 2'b10,
    ISCD_FAULT = 2'b11
  } iscd_state_type;
endpackage

/* File: verilog/iscd_coproc2_opcode_mask.sv */
// Purpose: Per-instruction presence check for the coprocessor-2 group.
// Assumes: Opcode fields come from logic on the same clock.
// Notes: Purely combinational; the top registers the result.
`timescale 1ns/1ps
module iscd_coproc2_opcode_mask #(
  parameter logic [5:0] COPROC2_OPCODE_INSTR_MASK = 6'h3f
) (
  input wire logic [5:0] opcode,
  output logic coproc2_opcode_op,
  output logic coproc2_opcode_allowed
);
  import iscd_pkg::*;
  always_comb begin
    coproc2_opcode_op = 1'b1;
    coproc2_opcode_allowed = 1'b0;
    case (opcode)
      OP_COPROC2_OPCODE: coproc2_opcode_allowed = COPROC2_OPCODE_INSTR_MASK[0];
      OP_LWC2: coproc2_opcode_allowed = COPROC2_OPCODE_INSTR_MASK[1];
      OP_SWC2: coproc2_opcode_allowed = COPROC2_OPCODE_INSTR_MASK[2];
      OP_LDC2: coproc2_opcode_allowed = COPROC2_OPCODE_INSTR_MASK[3];
      OP_SDC2: coproc2_opcode_allowed = COPROC2_OPCODE_INSTR_MASK[4];
      default: coproc2_opcode_op = 1'b0;
    endcase
  end
endmodule // iscd_coproc2_opcode_mask

/* File: verilog/iscd_id_bits.sv */
// Purpose: Builds the read-only identification bits from build options.
// Assumes: Options are static for the life of the part.
// Notes: Combinational; registered in the top.
`timescale 1ns/1ps
module iscd_id_bits #(
  parameter bit HAS_FPU = 1'b1,
  parameter bit FPU_64 = 1'b1,
  parameter bit HAS_PS = 1'b0,
  parameter bit HAS_COPROC2_OPCODE = 1'b0,
  parameter bit ADDR_64 = 1'b1,
  parameter logic [2:0] ILINE = 3'h4,
  parameter logic [2:0] DLINE = 3'h4
) (
  output logic fpu_present_flag,
  output logic fpu64_capable,
  output logic paired_single_fmt,
  output logic coproc2_opcode_present_flag,
  output logic [1:0] address_width_field,
  output logic [2:0] icache_line_field,
  output logic [2:0] dcache_line_field
);
  import iscd_pkg::*;
  always_comb begin
    fpu_present_flag = HAS_FPU;
    fpu64_capable = HAS_FPU & FPU_64;
    paired_single_fmt = HAS_FPU & FPU_64 & HAS_PS;
    coproc2_opcode_present_flag = HAS_COPROC2_OPCODE;
    address_width_field = ADDR_64 ? AW_64 : AW_32;
    icache_line_field = ILINE;
    dcache_line_field = DLINE;
  end
endmodule // iscd_id_bits

/* File: verilog/iscd_decode.sv */
// Purpose: Decides which optional instruction groups exist and traps the rest.
// Assumes: One instruction offered per cycle with instr_valid from the pipeline.
// Notes: Feature set is fixed by parameters; verdict appears one cycle later.
`timescale 1ns/1ps
module iscd_decode #(
  parameter logic [2:0] RELEASE = 3'h6,
  parameter bit HAS_FPU = 1'b1,
  parameter bit FPU_64 = 1'b1,
  parameter bit HAS_PS = 1'b0,
  parameter bit HAS_COPROC2_OPCODE = 1'b0,
  parameter logic [5:0] COPROC2_OPCODE_INSTR_MASK = 6'h3f,
  parameter bit ADDR_64 = 1'b1,
  parameter logic [2:0] ILINE = 3'h4,
  parameter logic [2:0] DLINE = 3'h4,
  parameter bit HAS_DEBUG = 1'b1,
  parameter bit HAS_VIRT = 1'b0,
  parameter bit HAS_SIMD = 1'b0,
  parameter bit MODE_SWITCH = 1'b0,
  parameter bit VENDOR_EXT = 1'b0,
  parameter bit COMPACT_WIDTH_MATCH = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic fpu_reg_model,
  output logic decode_valid,
  output logic [1:0] exc_code,
  output logic config_ok,
  output logic fpu_present_flag,
  output logic fpu64_capable,
  output logic paired_single_fmt,
  output logic coproc2_opcode_present_flag,
  output logic [1:0] address_width_field,
  output logic [2:0] icache_line_field,
  output logic [2:0] dcache_line_field
);
  import iscd_pkg::*;

  // A release-5 feature lifts the effective release to at least five.
  localparam logic [2:0] EFF_REL =
    ((HAS_VIRT | HAS_SIMD) && RELEASE < REL_FIVE) ? REL_FIVE : RELEASE;

  // Illegal builds are caught once after reset and then trap every valid
  // instruction, so a bad configuration is visible on config_ok.
  function automatic logic legal_cfg(input logic model);
    logic ok;
    ok = 1'b1;
    if (HAS_FPU && !FPU_64 && EFF_REL != REL_SIX) ok = 1'b0;
    if (HAS_FPU && !FPU_64 && model) ok = 1'b0;
    if (HAS_FPU && FPU_64 && EFF_REL == REL_SIX && !model) ok = 1'b0;
    if (HAS_PS && EFF_REL == REL_SIX) ok = 1'b0;
    if (HAS_PS && !FPU_64) ok = 1'b0;
    if (VENDOR_EXT && EFF_REL == REL_SIX) ok = 1'b0;
    if (!COMPACT_WIDTH_MATCH) ok = 1'b0;
    return ok;
  endfunction

  // Register model 1 is usable only when the build supports it.
  function automatic logic model_supported(input logic model);
    logic ok;
    ok = 1'b1;
    if (model && !FPU_64) ok = 1'b0;
    if (!model && FPU_64 && EFF_REL == REL_SIX) ok = 1'b0;
    // Before release 5 model 0 is mandatory and model 1 also supported;
    // release 5 requires both, so both remain accepted there.
    return ok;
  endfunction

  logic coproc2_opcode_op;
  logic coproc2_opcode_allowed;
  logic id_fp, id_f64, id_ps, id_c2;
  logic [1:0] id_aw;
  logic [2:0] id_il, id_dl;

  iscd_coproc2_opcode_mask #(.COPROC2_OPCODE_INSTR_MASK(COPROC2_OPCODE_INSTR_MASK)) u_coproc2_opcode (
    .opcode(instr_word[31:26]),
    .coproc2_opcode_op(coproc2_opcode_op),
    .coproc2_opcode_allowed(coproc2_opcode_allowed)
  );

  iscd_id_bits #(
    .HAS_FPU(HAS_FPU), .FPU_64(FPU_64), .HAS_PS(HAS_PS && EFF_REL != REL_SIX),
    .HAS_COPROC2_OPCODE(HAS_COPROC2_OPCODE), .ADDR_64(ADDR_64), .ILINE(ILINE), .DLINE(DLINE)
  ) u_id (
    .fpu_present_flag(id_fp),
    .fpu64_capable(id_f64),
    .paired_single_fmt(id_ps),
    .coproc2_opcode_present_flag(id_c2),
    .address_width_field(id_aw),
    .icache_line_field(id_il),
    .dcache_line_field(id_dl)
  );

  iscd_state_type state_q, state_d;
  logic config_ok_q, config_ok_d;
  logic decode_valid_q, decode_valid_d;
  logic [1:0] exc_q, exc_d;
  logic fp_q, f64_q, ps_q, c2_q;
  logic [1:0] aw_q;
  logic [2:0] il_q, dl_q;

  logic [5:0] opc;
  logic [5:0] fn;
  logic fp_op;
  logic [1:0] verdict;

  assign opc = instr_word[31:26];
  assign fn = instr_word[5:0];

  // Every floating-point group, including its branch helpers and, before release six, the MOVCI move helper.
  assign fp_op = (opc == OP_COP1) || (opc == OP_LWC1) || (opc == OP_SWC1) ||
                 (opc == OP_LDC1) || (opc == OP_SDC1) ||
                 (opc == OP_SPECIAL && fn == FN_MOVCI && EFF_REL != REL_SIX);

  always_comb begin
    verdict = EXC_NONE;
    if (fp_op) begin
      if (!HAS_FPU) verdict = EXC_COP_UNUSABLE;
      else if (!model_supported(fpu_reg_model)) verdict = EXC_RESERVED;
    end else if (coproc2_opcode_op) begin
      if (!HAS_COPROC2_OPCODE) verdict = EXC_COP_UNUSABLE;
      else if (!coproc2_opcode_allowed) verdict = EXC_RESERVED;
    end else if (opc == OP_COPROC3_OPCODE && RELEASE >= REL_TWO) begin
      verdict = EXC_RESERVED;
    end else if (opc == OP_VENDOR) begin
      if (!VENDOR_EXT || EFF_REL == REL_SIX) verdict = EXC_RESERVED;
    end else if (opc == OP_MODE_JUMP) begin
      if (!MODE_SWITCH || EFF_REL == REL_SIX) verdict = EXC_RESERVED;
    end else if (opc == OP_SPECIAL && fn == FN_DEBUG_BREAK) begin
      if (!HAS_DEBUG) verdict = EXC_RESERVED;
    end else if (opc == OP_COP0 && fn == FN_DEBUG_RETURN && instr_word[25]) begin
      if (!HAS_DEBUG) verdict = EXC_RESERVED;
    end
  end

  always_comb begin
    state_d = state_q;
    config_ok_d = config_ok_q;
    decode_valid_d = 1'b0;
    exc_d = EXC_NONE;
    case (state_q)
      ISCD_BOOT: state_d = ISCD_CHECK;
      ISCD_CHECK: begin
        config_ok_d = legal_cfg(fpu_reg_model);
        state_d = legal_cfg(fpu_reg_model) ? ISCD_RUN : ISCD_FAULT;
      end
      ISCD_RUN: begin
        decode_valid_d = instr_valid;
        exc_d = instr_valid ? verdict : EXC_NONE;
      end
      // A bad build still traps every instruction so nothing executes.
      ISCD_FAULT: begin
        decode_valid_d = instr_valid;
        exc_d = instr_valid ? EXC_RESERVED : EXC_NONE;
      end
      default: state_d = ISCD_BOOT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ISCD_BOOT;
      config_ok_q <= 1'b0;
      decode_valid_q <= 1'b0;
      exc_q <= EXC_NONE;
    end else begin
      state_q <= state_d;
      config_ok_q <= config_ok_d;
      decode_valid_q <= decode_valid_d;
      exc_q <= exc_d;
    end
  end

  // Identification comes from the same parameters as the trap logic.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fp_q <= 1'b0;
      f64_q <= 1'b0;
      ps_q <= 1'b0;
      c2_q <= 1'b0;
      aw_q <= AW_32;
      il_q <= LINE_NONE;
      dl_q <= LINE_NONE;
    end else begin
      fp_q <= id_fp;
      f64_q <= id_f64;
      ps_q <= id_ps;
      c2_q <= id_c2;
      aw_q <= id_aw;
      il_q <= id_il;
      dl_q <= id_dl;
    end
  end

  // Reserved fields are never exported or given meaning here.
  assign decode_valid = decode_valid_q;
  assign exc_code = exc_q;
  assign config_ok = config_ok_q;
  assign fpu_present_flag = fp_q;
  assign fpu64_capable = f64_q;
  assign paired_single_fmt = ps_q;
  assign coproc2_opcode_present_flag = c2_q;
  assign address_width_field = aw_q;
  assign icache_line_field = il_q;
  assign dcache_line_field = dl_q;

  a_fpu_absent_trap: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && fp_op && !HAS_FPU)
    |=> exc_code == EXC_COP_UNUSABLE) else $error("fpu op not trapped");
  a_coproc3_opcode_reserved: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && opc == OP_COPROC3_OPCODE && RELEASE >= REL_TWO)
    |=> exc_code == EXC_RESERVED) else $error("coproc3_opcode not reserved");
  a_vendor_rel6: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && opc == OP_VENDOR && EFF_REL == REL_SIX)
    |=> exc_code == EXC_RESERVED) else $error("vendor group open");
  a_mode_jump: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && opc == OP_MODE_JUMP)
    |=> (exc_code == EXC_NONE) == (MODE_SWITCH && EFF_REL != REL_SIX))
    else $error("mode jump decode wrong");
  a_ps_rel6: assert property (@(posedge core_clk) disable iff (rst)
    (EFF_REL == REL_SIX) |-> ##1 !paired_single_fmt)
    else $error("paired single reported");
  a_integer_ok: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && opc == OP_SPECIAL && fn == 6'h20)
    |=> decode_valid && exc_code == EXC_NONE) else $error("integer trapped");
  a_id_agree: assert property (@(posedge core_clk) disable iff (rst)
    $rose(config_ok) |-> fpu_present_flag == HAS_FPU && coproc2_opcode_present_flag == HAS_COPROC2_OPCODE)
    else $error("id bits disagree");
  a_coproc2_opcode_absent: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && coproc2_opcode_op && !HAS_COPROC2_OPCODE)
    |=> exc_code == EXC_COP_UNUSABLE) else $error("coproc2_opcode not trapped");
  a_debug_absent: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && opc == OP_SPECIAL
     && fn == FN_DEBUG_BREAK && !HAS_DEBUG) |=> exc_code == EXC_RESERVED)
    else $error("debug break not trapped");
  a_aw_field: assert property (@(posedge core_clk) disable iff (rst)
    !rst ##1 1'b1 |-> address_width_field == (ADDR_64 ? AW_64 : AW_32))
    else $error("address width wrong");
  // A bad build, an idle cycle and the start-up states must trap or stay quiet.
  // Nothing may slip through as a clean answer while the build is unchecked.
  a_fault_traps: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_FAULT && instr_valid)
    |=> decode_valid && exc_code == EXC_RESERVED) else $error("bad build let op pass");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !instr_valid |=> !decode_valid && exc_code == EXC_NONE)
    else $error("answer without request");
  a_boot_silent: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_BOOT || state_q == ISCD_CHECK) |=> !decode_valid)
    else $error("answer before check");
  a_coproc2_opcode_partial: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && coproc2_opcode_op && HAS_COPROC2_OPCODE && !coproc2_opcode_allowed)
    |=> exc_code == EXC_RESERVED)
    else $error("omitted coproc2_opcode op not trapped");
  a_coproc2_opcode_kept: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && coproc2_opcode_op && HAS_COPROC2_OPCODE && coproc2_opcode_allowed)
    |=> decode_valid && exc_code == EXC_NONE)
    else $error("kept coproc2_opcode op trapped");
  a_fp_model: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && fp_op && HAS_FPU && FPU_64
     && EFF_REL == REL_SIX && !fpu_reg_model) |=> exc_code == EXC_RESERVED)
    else $error("model 0 float op accepted");
  a_fp_clean: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN && instr_valid && fp_op && HAS_FPU && FPU_64 && fpu_reg_model)
    |=> exc_code == EXC_NONE)
    else $error("float op trapped in model 1");
  a_id_static: assert property (@(posedge core_clk) disable iff (rst)
    config_ok |=> $stable(fpu_present_flag) && $stable(fpu64_capable)
    && $stable(coproc2_opcode_present_flag) && $stable(address_width_field))
    else $error("id bits changed");
  a_line_fields: assert property (@(posedge core_clk) disable iff (rst)
    !rst ##1 1'b1 |-> icache_line_field == ILINE && dcache_line_field == DLINE)
    else $error("cache line fields wrong");
  a_run_cfg_ok: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ISCD_RUN) == config_ok) else $error("config flag disagrees with state");
  c_run_reached: cover property (@(posedge core_clk) state_q == ISCD_RUN);
  c_fault_seen: cover property (@(posedge core_clk) state_q == ISCD_FAULT);
  c_trap_seen: cover property (@(posedge core_clk) exc_code == EXC_RESERVED);
  c_cu_seen: cover property (@(posedge core_clk) exc_code == EXC_COP_UNUSABLE);
  c_clean_op: cover property (@(posedge core_clk) decode_valid && exc_code == EXC_NONE);
endmodule // iscd_decode

/* File: tb/iscd_decode_test.sv */
// Purpose: Self-checking bench for the subset-configuration decoder.
// Assumes: Three builds share one stimulus stream: full release six, a lean
//   release three core with a partial coprocessor 2, and an illegal build.
// Notes: Each verdict is compared one cycle after the word is offered.
`timescale 1ns/1ps
module iscd_decode_test;
  import iscd_pkg::*;
  localparam logic [5:0] OPS [19] = '{6'h09, 6'h0c, 6'h0d, 6'h23, 6'h2b, OP_COP1, OP_LWC1,
    OP_LDC1, OP_SWC1, OP_SDC1, OP_COPROC2_OPCODE, OP_LWC2, OP_LDC2, OP_SWC2, OP_SDC2, OP_COPROC3_OPCODE,
    OP_VENDOR, OP_MODE_JUMP, OP_SPECIAL};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic fpu_reg_model = 1'b1;
  logic [2:0] dv, ok, fp, f64, ps, c2;
  logic [1:0] ex [3];
  logic [1:0] aw [3];
  logic [2:0] il [3];
  logic [2:0] dl [3];
  logic [1:0] pend_e [3];
  logic pend_v = 1'b0;
  logic [31:0] seed = 32'h60;
  logic [31:0] w;
  int errors = 0;
  int check_count = 0;
  // Build options of the lean core and of the illegal build.
  localparam logic [2:0] LEAN_RELEASE = 3'h3;
  localparam bit LEAN_FPU = 1'b0;
  localparam bit LEAN_FPU_64 = 1'b0;
  localparam bit LEAN_COPROC2_OPCODE = 1'b1;
  localparam logic [5:0] LEAN_COPROC2_OPCODE_MASK = 6'h05;
  localparam bit LEAN_ADDR_64 = 1'b0;
  localparam logic [2:0] LEAN_ILINE = 3'h0;
  localparam logic [2:0] LEAN_DLINE = 3'h3;
  localparam bit LEAN_DEBUG = 1'b0;
  localparam bit LEAN_MODE_SWITCH = 1'b1;
  localparam bit BAD_PS = 1'b1;

  iscd_decode iscd_decode_i (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .fpu_reg_model(fpu_reg_model), .decode_valid(dv[0]),
    .exc_code(ex[0]), .config_ok(ok[0]), .fpu_present_flag(fp[0]), .fpu64_capable(f64[0]),
    .paired_single_fmt(ps[0]), .coproc2_opcode_present_flag(c2[0]), .address_width_field(aw[0]),
    .icache_line_field(il[0]), .dcache_line_field(dl[0]));
  // A lean core: no floating point, narrow addresses, no instruction cache.
  iscd_decode #(.RELEASE(LEAN_RELEASE), .HAS_FPU(LEAN_FPU), .FPU_64(LEAN_FPU_64),
    .HAS_COPROC2_OPCODE(LEAN_COPROC2_OPCODE), .COPROC2_OPCODE_INSTR_MASK(LEAN_COPROC2_OPCODE_MASK), .ADDR_64(LEAN_ADDR_64),
    .ILINE(LEAN_ILINE), .DLINE(LEAN_DLINE), .HAS_DEBUG(LEAN_DEBUG),
    .MODE_SWITCH(LEAN_MODE_SWITCH)) iscd_decode_lean_i (.core_clk(core_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .fpu_reg_model(fpu_reg_model),
    .decode_valid(dv[1]), .exc_code(ex[1]), .config_ok(ok[1]), .fpu_present_flag(fp[1]),
    .fpu64_capable(f64[1]), .paired_single_fmt(ps[1]), .coproc2_opcode_present_flag(c2[1]),
    .address_width_field(aw[1]), .icache_line_field(il[1]), .dcache_line_field(dl[1]));
  // Paired single on the newest release is an illegal build.
  iscd_decode #(.HAS_PS(BAD_PS)) iscd_decode_bad_i (.core_clk(core_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .fpu_reg_model(fpu_reg_model),
    .decode_valid(dv[2]), .exc_code(ex[2]), .config_ok(ok[2]), .fpu_present_flag(fp[2]),
    .fpu64_capable(f64[2]), .paired_single_fmt(ps[2]), .coproc2_opcode_present_flag(c2[2]),
    .address_width_field(aw[2]), .icache_line_field(il[2]), .dcache_line_field(dl[2]));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic is_fp(input logic [5:0] op);
    return op inside {OP_COP1, OP_LWC1, OP_LDC1, OP_SWC1, OP_SDC1};
  endfunction

  function automatic logic [31:0] pick(input logic [31:0] r);
    logic [5:0] op;
    op = OPS[r[31:27] % 19];
    // Reserved zero fields stay zero so that only the feature set decides the verdict.
    if (op == OP_SPECIAL) begin
      return {OP_SPECIAL, r[25:11], 5'h00, (r[0] ? 6'h20 : FN_DEBUG_BREAK)};
    end
    if (op == OP_COP1) begin
      return {OP_COP1, 5'h10, r[20:6], 6'h05};
    end
    return {op, r[25:0]};
  endfunction

  function automatic logic [1:0] exp_full(input logic [31:0] x, input logic m);
    if (is_fp(x[31:26])) return m ? EXC_NONE : EXC_RESERVED;
    if (x[31:26] inside {OP_COPROC2_OPCODE, OP_LWC2, OP_LDC2, OP_SWC2, OP_SDC2}) return EXC_COP_UNUSABLE;
    if (x[31:26] inside {OP_COPROC3_OPCODE, OP_VENDOR, OP_MODE_JUMP}) return EXC_RESERVED;
    return EXC_NONE;
  endfunction

  function automatic logic [1:0] exp_lean(input logic [31:0] x);
    if (is_fp(x[31:26])) return EXC_COP_UNUSABLE;
    if (x[31:26] == OP_SPECIAL && x[5:0] == FN_MOVCI) return EXC_COP_UNUSABLE;
    if (x[31:26] inside {OP_COPROC2_OPCODE, OP_SWC2, OP_MODE_JUMP}) return EXC_NONE;
    if (x[31:26] inside {OP_LWC2, OP_LDC2, OP_SDC2, OP_COPROC3_OPCODE, OP_VENDOR}) return EXC_RESERVED;
    if (x[31:26] == OP_COP0 && x[25] && x[5:0] == FN_DEBUG_RETURN) return EXC_RESERVED;
    if (x[31:26] == OP_SPECIAL && x[5:0] == FN_DEBUG_BREAK) return EXC_RESERVED;
    return EXC_NONE;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input logic v, input logic [31:0] x, input logic m);
    @(posedge core_clk);
    instr_valid <= v;
    instr_word <= x;
    fpu_reg_model <= m;
    #1;
    for (int i = 0; i < 3; i++) begin
      chk(dv[i], pend_v, "decode valid");
      chk(ex[i], pend_v ? pend_e[i] : EXC_NONE, "exception code");
    end
    pend_v = v;
    pend_e[0] = exp_full(x, m);
    pend_e[1] = exp_lean(x);
    pend_e[2] = EXC_RESERVED;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    $display("[ERR] %0t run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    instr_valid <= 1'b1;
    instr_word <= {OP_COPROC3_OPCODE, 26'h0};
    #1;
    chk(ok, 3'b000, "config during reset");
    repeat (3) step(1'b0, 32'h0, 1'b1);
    chk(ok, 3'b011, "config ok");
    chk(fp, 3'b101, "fpu present");
    chk(f64, 3'b101, "fpu 64 capable");
    chk(ps, 3'b000, "paired single");
    chk(c2, 3'b010, "coproc2_opcode present");
    chk({aw[0], aw[1]}, {AW_64, AW_32}, "address width");
    chk({il[0], il[1], dl[0], dl[1]}, {3'h4, LINE_NONE, 3'h4, 3'h3}, "cache lines");
    step(1'b1, {OP_COPROC3_OPCODE, 26'h0}, 1'b1);
    step(1'b1, {OP_VENDOR, 26'h0}, 1'b1);
    step(1'b1, {OP_MODE_JUMP, 26'h0}, 1'b1);
    step(1'b1, {OP_SPECIAL, 20'h0, FN_DEBUG_BREAK}, 1'b1);
    step(1'b1, {OP_COP0, 1'b1, 19'h0, FN_DEBUG_RETURN}, 1'b1);
    step(1'b1, {OP_COP1, 5'h10, 15'h0, 6'h05}, 1'b0);
    step(1'b1, {OP_LDC1, 26'h0}, 1'b1);
    step(1'b1, {OP_SPECIAL, 20'h0, FN_MOVCI}, 1'b1);
    for (int k = 10; k < 15; k++) step(1'b1, {OPS[k], 26'h0}, 1'b1);
    repeat (2000) begin
      seed = xs(seed);
      w = pick(seed);
      step(seed[1] | seed[2], w, is_fp(w[31:26]) ? seed[3] : 1'b1);
    end
    step(1'b0, 32'h0, 1'b1);
    // A second reset in mid-run must rebuild the same configuration.
    rst <= 1'b1;
    repeat (3) step(1'b0, 32'h0, 1'b1);
    rst <= 1'b0;
    repeat (3) step(1'b0, 32'h0, 1'b1);
    chk(ok, 3'b011, "config after second reset");
    step(1'b1, {OP_COPROC3_OPCODE, 26'h0}, 1'b1);
    step(1'b0, 32'h0, 1'b1);
    tally_and_finish();
  end
endmodule // iscd_decode_test
